/* File: engine_model.sv */
// behavioural bit engine beside the control block
// answers each start, restart or byte request lat plus eight cycles later; only the address event carries ack
`timescale 1ns/1ps
module engine_model (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // requests
  input  wire       start_req,
  input  wire       restart_req,
  input  wire       byte_req,
  input  wire       stop_req,
  input  wire [7:0] addr_out,
  // bench settings
  input  wire [3:0] lat,
  input  wire [7:0] rx_byte,
  // events
  output reg        eng_addr_done,
  output reg        eng_byte_sent,
  output reg        eng_byte_read,
  output reg  [7:0] eng_rx_data,
  output reg        eng_ack_in,
  output reg        eng_owner,
  output wire       scl_pin,
  output wire       sda_pin
);
  reg  [4:0] cnt_reg;
  reg  [1:0] kind_reg;
  wire       fin = (cnt_reg == 5'd1);
  // lines move only inside a frame, pulled high otherwise
  assign scl_pin = (cnt_reg == 5'd0) | cnt_reg[2];
  assign sda_pin = (cnt_reg == 5'd0) | cnt_reg[3];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 5'd0;
      kind_reg <= 2'd0;
      eng_addr_done <= 1'b0;
      eng_byte_sent <= 1'b0;
      eng_byte_read <= 1'b0;
      eng_rx_data <= 8'h00;
      eng_ack_in <= 1'b1;
      eng_owner <= 1'b0;
    end else begin
      eng_addr_done <= fin && kind_reg == 2'd1;
      eng_byte_read <= fin && kind_reg == 2'd2;
      eng_byte_sent <= fin && kind_reg == 2'd3;
      // data and ack hold meaning only with their pulse
      eng_rx_data <= (fin && kind_reg == 2'd2) ? rx_byte : ~eng_rx_data;
      eng_ack_in <= !(fin && kind_reg == 2'd1);
      if (cnt_reg != 5'd0)
        cnt_reg <= cnt_reg - 5'd1;
      if (start_req | restart_req | byte_req) begin
        cnt_reg <= {1'b0, lat} + 5'd8;
        kind_reg <= (start_req | restart_req) ? 2'd1 : (addr_out[0] ? 2'd2 : 2'd3);
        eng_owner <= 1'b1;
      end
      if (stop_req)
        eng_owner <= 1'b0;
    end
  end
endmodule // engine_model

/* File: idle_timeout.v */
// inactive-bus supervisor: counts clock cycles without line activity
// assumes activity is a one-cycle pulse on the same clock as pclk
`timescale 1ns/1ps
`include "two_wire_master_consts.vh"

module idle_timeout #(
  parameter W = 13
) (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // control
  input  wire [1:0] select,
  input  wire       run,
  input  wire       activity,
  // result
  output reg        expired
);

  reg  [W-1:0] count_reg;
  reg  [W-1:0] limit;

  // terminal counts held at 32 bits, cut to the counter width below
  localparam [31:0] LIMIT_1 = `TIMEOUT_1_CYC;
  localparam [31:0] LIMIT_2 = `TIMEOUT_2_CYC;
  localparam [31:0] LIMIT_3 = `TIMEOUT_3_CYC;

  // ==========================================================
  // terminal count
  always @* begin
    case (select)
      2'h1:    limit = LIMIT_1[W-1:0];
      2'h2:    limit = LIMIT_2[W-1:0];
      2'h3:    limit = LIMIT_3[W-1:0];
      default: limit = {W{1'b0}};
    endcase
  end

  // ==========================================================
  // counter restarted by any line change
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {W{1'b0}};
      expired   <= 1'b0;
    end else begin
      expired <= 1'b0;
      if (select == 2'h0 || activity || !run) begin
        count_reg <= {W{1'b0}};
      end else if (count_reg >= limit) begin
        count_reg <= {W{1'b0}};
        expired   <= 1'b1;
      end else begin
        count_reg <= count_reg + {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // idle_timeout

/* File: two_wire_master_consts.vh */
// constants for the two-wire master control block
// included by the master control and idle timeout modules
`ifndef TWO_WIRE_MASTER_CONSTS_VH
`define TWO_WIRE_MASTER_CONSTS_VH

// ==========================================================
// register indices (byte address is four times the index)
`define IDX_DEBUG_CONTROL    8'h02
`define IDX_MASTER_CONTROL_A 8'h03
`define IDX_MASTER_CONTROL_B 8'h04
`define IDX_MASTER_STATUS    8'h05
`define IDX_MASTER_ADDRESS   8'h07
`define IDX_MASTER_DATA      8'h08

// ==========================================================
// master_control_a fields
`define CA_READ_IRQ_EN  7
`define CA_WRITE_IRQ_EN 6
`define CA_QUICK_CMD    4
`define CA_TIMEOUT_HI   3
`define CA_TIMEOUT_LO   2
`define CA_AUTO_ACK     1
`define CA_ENABLE       0
`define CA_WRITE_MASK   8'hdf

// ==========================================================
// master_control_b fields
`define CB_FLUSH   3
`define CB_ACK     2
`define CB_CMD_HI  1
`define CB_CMD_LO  0

// ==========================================================
// master_status fields
`define ST_READ_DONE  7
`define ST_WRITE_DONE 6
`define ST_SCL_HELD   5
`define ST_LAST_ACK   4
`define ST_ARB_LOST   3
`define ST_BUS_ERROR  2

// ==========================================================
// reset values
`define RESET_BYTE 8'h00

// ==========================================================
// commands and bus conditions
`define CMD_NONE          2'h0
`define CMD_RESTART       2'h1
`define CMD_BYTE_TRANSFER 2'h2
`define CMD_STOP          2'h3
`define BUS_UNKNOWN       2'h0
`define BUS_IDLE          2'h1
`define BUS_OWNER         2'h2
`define BUS_BUSY          2'h3

// ==========================================================
// timing: clock period and inactive-bus times in ns
`define CLK_PERIOD_NS 50
`define TIMEOUT_1_NS  50000
`define TIMEOUT_2_NS  100000
`define TIMEOUT_3_NS  200000
`define TIMEOUT_1_CYC ((`TIMEOUT_1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMEOUT_2_CYC ((`TIMEOUT_2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TIMEOUT_3_CYC ((`TIMEOUT_3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* File: two_wire_master_control.v */
// control, command and status logic of a two-wire bus master
// assumes an APB master on pclk and a bit engine on pclk beside it
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "two_wire_master_consts.vh"

module two_wire_master_control #(
  parameter TIMER_W = 13
) (
  // clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // apb slave
  input  wire       psel,
  input  wire       penable,
  input  wire       pwrite,
  input  wire [7:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg        pready,
  output reg        pslverr,
  // cpu side
  input  wire       cpu_global_irq,
  input  wire       cpu_debug_halt,
  output reg        master_irq,
  // bus lines as seen on the pins
  input  wire       scl_pin,
  input  wire       sda_pin,
  // bit engine events
  input  wire       eng_addr_done,
  input  wire       eng_byte_sent,
  input  wire       eng_byte_read,
  input  wire [7:0] eng_rx_data,
  input  wire       eng_ack_in,
  input  wire       eng_arb_lost,
  input  wire       eng_bus_error,
  input  wire       eng_scl_held,
  input  wire       eng_owner,
  // bit engine requests
  output reg        master_active,
  output reg        flush_strobe,
  output reg        start_req,
  output reg        restart_req,
  output reg        byte_req,
  output reg        stop_req,
  output reg        ack_req,
  output reg        ack_value,
  output reg  [7:0] addr_out,
  output reg  [7:0] data_out
);

  // ==========================================================
  // state
  reg        run_in_debug_halt;
  reg  [7:0] master_control_a;
  reg        ack_choice;
  reg        read_done_flag;
  reg        write_done_flag;
  reg        scl_held_low;
  reg        last_ack_received;
  reg        arbitration_lost_flag;
  reg        bus_error_flag;
  reg  [1:0] bus_condition;
  reg  [7:0] master_address_reg;
  reg  [7:0] master_data_reg;
  reg        send_pending;
  reg        scl_meta;
  reg        scl_sync;
  reg        sda_meta;
  reg        sda_sync;
  reg        scl_prev;
  reg        sda_prev;
  reg        owner_prev;
  wire       idle_expired;

  // ==========================================================
  // decode
  function hit;
    input [7:0] a;
    input [7:0] idx;
    begin
      hit = (a == {idx[5:0], 2'b00});
    end
  endfunction
  wire setup_phase = psel && !penable;
  wire access_done = psel && penable && pready;
  wire wr          = access_done && pwrite;
  wire rd          = access_done && !pwrite;
  wire wr_dbg      = wr && hit(paddr, `IDX_DEBUG_CONTROL);
  wire wr_ca       = wr && hit(paddr, `IDX_MASTER_CONTROL_A);
  wire wr_cb       = wr && hit(paddr, `IDX_MASTER_CONTROL_B);
  wire wr_st       = wr && hit(paddr, `IDX_MASTER_STATUS);
  wire wr_addr     = wr && hit(paddr, `IDX_MASTER_ADDRESS);
  wire wr_data     = wr && hit(paddr, `IDX_MASTER_DATA);
  wire rd_data     = rd && hit(paddr, `IDX_MASTER_DATA);
  wire mapped      = hit(paddr, `IDX_DEBUG_CONTROL) || hit(paddr, `IDX_MASTER_CONTROL_A) ||
                     hit(paddr, `IDX_MASTER_CONTROL_B) || hit(paddr, `IDX_MASTER_STATUS) ||
                     hit(paddr, `IDX_MASTER_ADDRESS) || hit(paddr, `IDX_MASTER_DATA);

  wire       enabled   = master_control_a[`CA_ENABLE];
  wire       running   = enabled && (!cpu_debug_halt || run_in_debug_halt);
  wire [1:0] wcmd      = pwdata[`CB_CMD_HI:`CB_CMD_LO];
  wire       wack      = pwdata[`CB_ACK];
  wire       flush     = wr_cb && pwdata[`CB_FLUSH];
  wire       cmd_valid = wr_cb && running && (wcmd != `CMD_NONE);
  wire       read_dir  = master_address_reg[0];
  wire       smart_ack = rd_data && running && master_control_a[`CA_AUTO_ACK];
  wire       flag_clr  = wr_addr || wr_data || rd_data || cmd_valid || flush;
  wire       ev_ok     = running;
  wire       addr_ack  = ev_ok && eng_addr_done && !eng_ack_in;
  wire       quick     = master_control_a[`CA_QUICK_CMD];

  // ==========================================================
  // pin synchronisers and line activity
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
      owner_prev <= 1'b0;
    end else begin
      scl_meta <= scl_pin;
      scl_sync <= scl_meta;
      sda_meta <= sda_pin;
      sda_sync <= sda_meta;
      scl_prev <= scl_sync;
      sda_prev <= sda_sync;
      owner_prev <= eng_owner;
    end
  end

  wire line_change = (scl_sync != scl_prev) || (sda_sync != sda_prev);
  wire start_seen  = scl_sync && scl_prev && sda_prev && !sda_sync;
  wire stop_seen   = scl_sync && scl_prev && !sda_prev && sda_sync;
  idle_timeout #(
    .W (TIMER_W)
  ) u_idle_timeout (
    .pclk     (pclk),
    .presetn  (presetn),
    .select   (master_control_a[`CA_TIMEOUT_HI:`CA_TIMEOUT_LO]),
    .run      (running),
    .activity (line_change),
    .expired  (idle_expired)
  );

  // ==========================================================
  // apb answer: data latched in setup, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup_phase) begin
        pslverr <= !mapped;
        prdata  <= 32'h00000000;
        if (hit(paddr, `IDX_DEBUG_CONTROL))
          prdata[0] <= run_in_debug_halt;
        if (hit(paddr, `IDX_MASTER_CONTROL_A))
          prdata[7:0] <= master_control_a;
        if (hit(paddr, `IDX_MASTER_CONTROL_B))
          prdata[`CB_ACK] <= ack_choice;
        if (hit(paddr, `IDX_MASTER_STATUS))
          prdata[7:0] <= {read_done_flag, write_done_flag, scl_held_low, last_ack_received,
                          arbitration_lost_flag, bus_error_flag, bus_condition};
        if (hit(paddr, `IDX_MASTER_ADDRESS))
          prdata[7:0] <= master_address_reg;
        if (hit(paddr, `IDX_MASTER_DATA))
          prdata[7:0] <= master_data_reg;
      end
    end
  end

  // ==========================================================
  // control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_in_debug_halt <= 1'b0;
      master_control_a  <= `RESET_BYTE;
      ack_choice        <= 1'b0;
    end else begin
      if (wr_dbg)
        run_in_debug_halt <= pwdata[0];
      if (wr_ca)
        master_control_a <= pwdata[7:0] & `CA_WRITE_MASK;
      if (wr_cb)
        ack_choice <= wack;
    end
  end

  // ==========================================================
  // address and data registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_address_reg <= `RESET_BYTE;
      master_data_reg    <= `RESET_BYTE;
    end else if (flush) begin
      master_address_reg <= `RESET_BYTE;
      master_data_reg    <= `RESET_BYTE;
    end else begin
      if (wr_addr)
        master_address_reg <= pwdata[7:0];
      if (wr_data)
        master_data_reg <= pwdata[7:0];
      else if (ev_ok && eng_byte_read)
        master_data_reg <= eng_rx_data;
    end
  end

  // ==========================================================
  // status flags; hardware set wins over any clear, but flush wins over the engine load of last_ack_received
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_done_flag        <= 1'b0;
      write_done_flag       <= 1'b0;
      scl_held_low          <= 1'b0;
      last_ack_received     <= 1'b0;
      arbitration_lost_flag <= 1'b0;
      bus_error_flag        <= 1'b0;
    end else begin
      if (flag_clr || (wr_st && pwdata[`ST_READ_DONE]))
        read_done_flag <= 1'b0;
      if (flag_clr || (wr_st && pwdata[`ST_WRITE_DONE]))
        write_done_flag <= 1'b0;
      if (flag_clr || (wr_st && pwdata[`ST_SCL_HELD]))
        scl_held_low <= 1'b0;
      if (flag_clr || (wr_st && pwdata[`ST_ARB_LOST]))
        arbitration_lost_flag <= 1'b0;
      if (flag_clr || (wr_st && pwdata[`ST_BUS_ERROR]))
        bus_error_flag <= 1'b0;
      if (flush)
        last_ack_received <= 1'b0;
      else if (ev_ok && eng_addr_done)
        last_ack_received <= eng_ack_in;
      if (ev_ok && eng_byte_read && !eng_arb_lost && !eng_bus_error && !last_ack_received)
        read_done_flag <= 1'b1;
      if (addr_ack && quick && read_dir)
        read_done_flag <= 1'b1;
      if (ev_ok && (eng_addr_done || eng_byte_sent))
        write_done_flag <= 1'b1;
      if (ev_ok && eng_scl_held)
        scl_held_low <= 1'b1;
      if (ev_ok && eng_arb_lost)
        arbitration_lost_flag <= 1'b1;
      if (ev_ok && eng_bus_error)
        bus_error_flag <= 1'b1;
      if (wr_addr && running && bus_condition == `BUS_UNKNOWN) begin
        write_done_flag <= 1'b1;
        bus_error_flag  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // bus condition tracking
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_condition <= `BUS_UNKNOWN;
    end else if (!enabled || flush) begin
      bus_condition <= `BUS_UNKNOWN;
    end else if (running) begin
      if (wr_st && pwdata[1:0] == `BUS_IDLE)
        bus_condition <= `BUS_IDLE;
      else if (idle_expired)
        bus_condition <= `BUS_IDLE;
      else if (eng_owner && (!owner_prev || bus_condition == `BUS_OWNER)) // forced idle sticks until a new claim
        bus_condition <= `BUS_OWNER;
      else if (stop_seen)
        bus_condition <= `BUS_IDLE;
      else if (start_seen || bus_condition == `BUS_OWNER)
        bus_condition <= `BUS_BUSY;
    end
  end

  // ==========================================================
  // engine requests: one-cycle pulses; master_active, ack_value, addr_out and data_out are held levels
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_active <= 1'b0;
      flush_strobe  <= 1'b0;
      start_req     <= 1'b0;
      restart_req   <= 1'b0;
      byte_req      <= 1'b0;
      stop_req      <= 1'b0;
      ack_req       <= 1'b0;
      ack_value     <= 1'b0;
      send_pending  <= 1'b0;
      addr_out      <= `RESET_BYTE;
      data_out      <= `RESET_BYTE;
    end else begin
      master_active <= running && !flush;
      flush_strobe  <= flush;
      start_req     <= 1'b0;
      restart_req   <= 1'b0;
      byte_req      <= 1'b0;
      stop_req      <= 1'b0;
      ack_req       <= 1'b0;
      addr_out      <= master_address_reg;
      data_out      <= master_data_reg;
      if (flush || !running) begin
        send_pending <= 1'b0;
      end else begin
        if (wr_addr && bus_condition != `BUS_UNKNOWN)
          start_req <= 1'b1;
        if (smart_ack && !ack_choice) begin
          ack_req   <= 1'b1;
          ack_value <= 1'b0;
          byte_req  <= read_dir;
        end
        if (cmd_valid) begin
          ack_req   <= read_dir;
          ack_value <= wack;
          case (wcmd)
            `CMD_RESTART:       restart_req <= 1'b1;
            `CMD_BYTE_TRANSFER: begin
              if (read_dir)
                byte_req <= 1'b1;
              else
                send_pending <= 1'b1;
            end
            `CMD_STOP:          stop_req <= 1'b1;
            default:            stop_req <= 1'b0;
          endcase
        end else if (send_pending && wr_data) begin
          send_pending <= 1'b0;
          byte_req     <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // interrupt request, one level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      master_irq <= 1'b0;
    else
      master_irq <= cpu_global_irq &&
                    ((master_control_a[`CA_READ_IRQ_EN] && read_done_flag) ||
                     (master_control_a[`CA_WRITE_IRQ_EN] && write_done_flag));
  end

endmodule // two_wire_master_control

/* File: two_wire_master_control_test.sv */
// self-checking bench for the two-wire master control block
// assumes the engine model and the checker are compiled before it
`timescale 1ns/1ps
module two_wire_master_control_test;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00;
  reg  [31:0] pwdata = 32'h0;
  reg         gie = 1'b0;
  reg         dbg = 1'b0;
  reg  [3:0]  lat = 4'h0;
  reg  [7:0]  rx = 8'h00;
  reg  [2:0]  fault = 3'h0;
  reg  [7:0]  q, v;
  reg         e;
  reg         ackv = 1'b1;
  integer     err_total = 0;
  integer     comparisons = 0;
  integer     i;
  wire [31:0] prdata;
  wire        pready, pslverr, master_irq, master_active, flush_strobe, ack_req, ack_value;
  wire        start_req, restart_req, byte_req, stop_req, scl_pin, sda_pin, ad, bs, br, ack_in, own;
  wire [7:0]  addr_out, data_out, rxd;

  two_wire_master_control two_wire_master_control_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_global_irq(gie), .cpu_debug_halt(dbg), .master_irq(master_irq),
    .scl_pin(scl_pin), .sda_pin(sda_pin), .eng_addr_done(ad), .eng_byte_sent(bs), .eng_byte_read(br),
    .eng_rx_data(rxd), .eng_ack_in(ack_in), .eng_arb_lost(fault[0]), .eng_bus_error(fault[1]),
    .eng_scl_held(fault[2]), .eng_owner(own), .master_active(master_active), .flush_strobe(flush_strobe),
    .start_req(start_req), .restart_req(restart_req), .byte_req(byte_req), .stop_req(stop_req),
    .ack_req(ack_req), .ack_value(ack_value), .addr_out(addr_out), .data_out(data_out));
  engine_model engine_model_inst (.pclk(pclk), .presetn(presetn), .start_req(start_req),
    .restart_req(restart_req), .byte_req(byte_req), .stop_req(stop_req), .addr_out(addr_out), .lat(lat),
    .rx_byte(rx), .eng_addr_done(ad), .eng_byte_sent(bs), .eng_byte_read(br), .eng_rx_data(rxd),
    .eng_ack_in(ack_in), .eng_owner(own), .scl_pin(scl_pin), .sda_pin(sda_pin));

  always #25 pclk = ~pclk;
  always @(posedge pclk) if (ack_req) ackv <= ack_value;

  function [7:0] tmo_unused_mask(input [7:0] d);
    tmo_unused_mask = d & 8'hdf;
  endfunction
  function integer tmo(input integer c);
    tmo = (50000 << (c - 1)) / 50;
  endfunction

  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      comparisons = comparisons + 1;
      if (g !== x) begin
        err_total = err_total + 1;
        $display("Error at %0t: got %h expected %h", $time, g, x);
      end
    end
  endtask
  task pause(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input w, input [7:0] a, input [7:0] d);
    integer n;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 100) begin
        n = n + 1;
        @(posedge pclk);
      end
      if (n == 100) begin
        err_total = err_total + 1;
        stop_test;
      end
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rdm(input [7:0] a, input [7:0] m, input [7:0] x);
    begin
      apb(1'b0, a, 8'h00);
      chk(q & m, x);
    end
  endtask

  initial begin
    i = $urandom(378);
    pause(8);
    presetn <= 1'b1;
    pause(1);
    rdm(8'h10, 8'hff, 8'h00);
    rdm(8'h14, 8'hff, 8'h00);
    rdm(8'h18, 8'hff, 8'h00);
    chk(e, 1'b1);
    for (i = 0; i < 6; i = i + 1) begin
      v = 8'($urandom);
      wr(8'h0c, v);
      rdm(8'h0c, 8'hff, tmo_unused_mask(v));
    end
    wr(8'h0c, 8'h00);
    wr(8'h1c, 8'ha1);
    wr(8'h0c, 8'h01);
    pause(1);
    chk(master_active, 1'b1);
    wr(8'h1c, 8'ha1);
    pause(4);
    rdm(8'h14, 8'hff, 8'h44);
    wr(8'h14, 8'h45);
    rdm(8'h14, 8'hff, 8'h01);
    wr(8'h14, 8'h12);
    rdm(8'h14, 8'hff, 8'h01);
    fault <= 3'h7;
    pause(1);
    fault <= 3'h0;
    rdm(8'h14, 8'h2c, 8'h2c);
    wr(8'h14, 8'h2c);
    rdm(8'h14, 8'h2c, 8'h00);
    wr(8'h0c, 8'hc1);
    lat <= 4'($urandom);
    rx <= 8'($urandom);
    wr(8'h1c, 8'ha1);
    pause(40);
    rdm(8'h14, 8'hfc, 8'h40);
    chk(master_irq, 1'b0);
    gie <= 1'b1;
    pause(3);
    chk(master_irq, 1'b1);
    wr(8'h10, 8'h02);
    pause(40);
    chk(ackv, 1'b0);
    rdm(8'h14, 8'hc0, 8'h80);
    chk(master_irq, 1'b1);
    rdm(8'h20, 8'hff, rx);
    pause(3);
    chk(master_irq, 1'b0);
    wr(8'h0c, 8'hc3);
    wr(8'h10, 8'h00);
    rdm(8'h20, 8'hff, rx);
    pause(40);
    rdm(8'h14, 8'h80, 8'h80);
    wr(8'h10, 8'h04);
    rdm(8'h20, 8'hff, rx);
    pause(40);
    rdm(8'h14, 8'h80, 8'h00);
    rdm(8'h10, 8'hff, 8'h04);
    wr(8'h0c, 8'hc1);
    wr(8'h10, 8'h06);
    pause(40);
    chk(ackv, 1'b1);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h10, i[7:0]);
      pause(40);
    end
    wr(8'h14, 8'h01);
    wr(8'h0c, 8'h11);
    wr(8'h1c, 8'ha1);
    pause(40);
    rdm(8'h14, 8'hc0, 8'hc0);
    wr(8'h10, 8'h03);
    wr(8'h14, 8'h01);
    wr(8'h1c, 8'ha0);
    pause(40);
    wr(8'h10, 8'h02);
    pause(40);
    rdm(8'h14, 8'h40, 8'h00);
    wr(8'h20, 8'h5a);
    pause(40);
    rdm(8'h14, 8'h40, 8'h40);
    chk(data_out, 8'h5a);
    wr(8'h10, 8'h08);
    pause(3);
    chk({addr_out, data_out}, 16'h0);
    dbg <= 1'b1;
    pause(4);
    chk(master_active, 1'b0);
    wr(8'h08, 8'h01);
    pause(3);
    chk(master_active, 1'b1);
    dbg <= 1'b0;
    for (i = 1; i < 4; i = i + 1) begin
      wr(8'h0c, {4'h0, i[1:0], 2'b01});
      wr(8'h10, 8'h03);
      wr(8'h14, 8'h01);
      wr(8'h1c, 8'ha1);
      pause(tmo(i) * 8 / 10);
      rdm(8'h14, 8'h03, 8'h02);
      pause(tmo(i) * 4 / 10);
      rdm(8'h14, 8'h03, 8'h01);
    end
    stop_test;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    err_total = err_total + 1;
    stop_test;
  end
endmodule // two_wire_master_control_test

/* File: two_wire_master_props.sv */
// assertions on the ports of the two-wire master control block
// assumes one pclk domain with presetn as its asynchronous reset
`timescale 1ns/1ps
module two_wire_master_props (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // cpu side
  input wire        cpu_global_irq,
  input wire        master_irq,
  // engine requests
  input wire        master_active,
  input wire        flush_strobe,
  input wire        start_req,
  input wire        restart_req,
  input wire        byte_req,
  input wire        stop_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel & penable;
  wire cmdw = acc & pwrite & (paddr == 8'h10);

  a_cmd_reads_zero: assert property (acc && !pwrite && paddr == 8'h10 |-> prdata[1:0] == 2'h0)
    else $error("command field read not zero");
  a_stop_follows: assert property (cmdw && pwdata[3:0] == 4'h3 && master_active |=> stop_req)
    else $error("stop command gave no stop request");
  a_restart_follows: assert property (cmdw && pwdata[3:0] == 4'h1 && master_active |=> restart_req)
    else $error("restart command gave no restart request");
  a_none_quiet: assert property (cmdw && pwdata[3:0] == 4'h0 |=> !(stop_req || restart_req))
    else $error("no-action command gave a request");
  a_flush_pulse: assert property (cmdw && pwdata[3] && master_active |=> flush_strobe ##1 !flush_strobe)
    else $error("flush strobe not one cycle");
  a_irq_gated: assert property (!$past(cpu_global_irq) |-> !master_irq)
    else $error("interrupt without global enable");
  a_active_off: assert property (acc && pwrite && paddr == 8'h0c && !pwdata[0] |-> ##2 !master_active)
    else $error("master still active after disable");
  a_req_needs_active: assert property (start_req || restart_req || byte_req || stop_req |-> $past(master_active))
    else $error("request while master inactive");
  a_off_no_start: assert property (acc && pwrite && paddr == 8'h1c && !master_active |=> !start_req [*3])
    else $error("start request while disabled");
endmodule // two_wire_master_props

bind two_wire_master_control two_wire_master_props two_wire_master_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .cpu_global_irq(cpu_global_irq), .master_irq(master_irq),
  .master_active(master_active), .flush_strobe(flush_strobe), .start_req(start_req),
  .restart_req(restart_req), .byte_req(byte_req), .stop_req(stop_req));
